// ===== verilog/cfb_core.sv
// Condition code, interrupt gate and bank pointer state of the core
//
// Functional notes
// - Half carry is set on carry or borrow from bit 3 into bit 4.
// - Interrupt enable gates servicing; reset clears it.
// - Two-bit level field holds the currently permitted level 0 to 3.
// - Request taken only if its level beats the field; field value 0 blocks.
// - Negative flag copies the result's top bit.
// - Zero flag is set exactly when the result is zero.
// - Overflow flag shows two's-complement overflow.
// - Carry flag shows carry or borrow out of bit 7.
// - Shifts load carry with the bit shifted out.
// - Direct bank pointer moves window 0080-00FF up in 80 hex steps.
// - Direct addresses 0000-007F are never remapped.
// - Register bank pointer selects the active register bank.
`timescale 1ns/1ps
`default_nettype none
module cfb_core
    import cfb_pkg::*;
#(
    parameter int RP_W = 5
)
(
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Instruction side operation request
    input wire logic alu_en_i,
    input wire cfb_op_e alu_op_i,
    input wire logic [7:0] alu_a_i,
    input wire logic [7:0] alu_b_i,
    output logic [7:0] alu_res_o,
    // Instruction side loads of whole registers
    input wire logic ccr_load_i,
    input wire logic [7:0] ccr_data_i,
    output logic [7:0] ccr_o,
    input wire logic rp_load_i,
    input wire logic [RP_W-1:0] rp_data_i,
    input wire logic dp_load_i,
    input wire logic [2:0] dp_data_i,
    // Interrupt gate
    input wire logic irq_req_i,
    input wire logic [1:0] irq_req_lvl_i,
    output logic irq_take_o,
    // Address forming
    input wire logic [7:0] dir_addr_i,
    output logic [10:0] dir_phys_o,
    input wire logic [2:0] reg_num_i,
    output logic [RP_W+2:0] gpr_phys_o
);
    // Arithmetic flags
    logic h_ff;
    logic n_ff;
    logic z_ff;
    logic v_ff;
    logic c_ff;
    // Interrupt control
    logic ie_ff;
    logic [1:0] il_ff;
    // Pointers
    logic [RP_W-1:0] rp_ff;
    logic [2:0] dp_ff;
    // Results and bus state
    logic [7:0] res_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [10:0] dir_phys_ff;
    logic [RP_W+2:0] gpr_phys_ff;
    // Combinational helpers
    logic bus_req;
    logic bus_stall;
    logic bus_acc;
    logic wr_ccr;
    logic wr_ptr;
    logic bus_alu_go;
    logic alu_go;
    logic [31:0] rd_mux;
    logic [10:0] map_dir;
    logic [RP_W+2:0] map_gpr;
    cfb_op_e bus_op;

    cfb_alu_if alu_bus ();

    // Bus request decode and acceptance
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_stall = avs_write_i & (avs_address_i == CFB_ALU_OFS)
                       & alu_en_i;
    assign bus_acc = bus_req & ack_ff & ~bus_stall;
    assign avs_waitrequest_o = bus_req & ~(ack_ff & ~bus_stall);
    assign wr_ccr = bus_acc & avs_write_i
                    & (avs_address_i == CFB_CCR_OFS);
    assign wr_ptr = bus_acc & avs_write_i
                    & (avs_address_i == CFB_PTR_OFS);
    assign bus_alu_go = bus_acc & avs_write_i
                        & (avs_address_i == CFB_ALU_OFS)
                        & (&avs_byteenable_i[2:0]);
    assign bus_op = cfb_op_e'(avs_writedata_i[CFB_OP_POS +: 4]);

    // One wait cycle per transfer, longer for an operation write while the core owns the unit
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req & ~(ack_ff & ~bus_stall);
        end
    end

    // Operand source: the core has priority over software
    assign alu_go = alu_en_i | bus_alu_go;
    always_comb begin
        if (alu_en_i) begin
            alu_bus.op = alu_op_i;
            alu_bus.a = alu_a_i;
            alu_bus.b = alu_b_i;
        end else begin
            alu_bus.op = bus_op;
            alu_bus.a = avs_writedata_i[CFB_OPA_POS +: 8];
            alu_bus.b = avs_writedata_i[CFB_OPB_POS +: 8];
        end
    end
    assign alu_bus.c_in = c_ff;
    assign alu_bus.h_in = h_ff;
    assign alu_bus.v_in = v_ff;

    cfb_alu_unit u_alu (
        .alu (alu_bus)
    );

    // Arithmetic flags: bus write, then core load, then operation
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            h_ff <= CFB_CCR_RST[CFB_H_POS];
            n_ff <= CFB_CCR_RST[CFB_N_POS];
            z_ff <= CFB_CCR_RST[CFB_Z_POS];
            v_ff <= CFB_CCR_RST[CFB_V_POS];
            c_ff <= CFB_CCR_RST[CFB_C_POS];
        end else if (wr_ccr && avs_byteenable_i[0]) begin
            h_ff <= avs_writedata_i[CFB_H_POS];
            n_ff <= avs_writedata_i[CFB_N_POS];
            z_ff <= avs_writedata_i[CFB_Z_POS];
            v_ff <= avs_writedata_i[CFB_V_POS];
            c_ff <= avs_writedata_i[CFB_C_POS];
        end else if (ccr_load_i) begin
            h_ff <= ccr_data_i[CFB_H_POS];
            n_ff <= ccr_data_i[CFB_N_POS];
            z_ff <= ccr_data_i[CFB_Z_POS];
            v_ff <= ccr_data_i[CFB_V_POS];
            c_ff <= ccr_data_i[CFB_C_POS];
        end else if (alu_go) begin
            h_ff <= alu_bus.h;
            n_ff <= alu_bus.n;
            z_ff <= alu_bus.z;
            v_ff <= alu_bus.v;
            c_ff <= alu_bus.c;
        end
    end

    // Interrupt enable and level field
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ie_ff <= CFB_CCR_RST[CFB_IE_POS];
            il_ff <= CFB_CCR_RST[CFB_IL_HI_POS:CFB_IL_LO_POS];
        end else if (wr_ccr && avs_byteenable_i[0]) begin
            ie_ff <= avs_writedata_i[CFB_IE_POS];
            il_ff <= avs_writedata_i[CFB_IL_HI_POS:CFB_IL_LO_POS];
        end else if (ccr_load_i) begin
            ie_ff <= ccr_data_i[CFB_IE_POS];
            il_ff <= ccr_data_i[CFB_IL_HI_POS:CFB_IL_LO_POS];
        end
    end

    // Lower level number is higher priority; level 3 never passes
    assign irq_take_o = irq_req_i & ie_ff
                        & (irq_req_lvl_i < il_ff);

    // Bank pointers, byte lane 0 and lane 1
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rp_ff <= '0;
            dp_ff <= CFB_DP_RST;
        end else begin
            if (wr_ptr && avs_byteenable_i[0]) begin
                rp_ff <= avs_writedata_i[CFB_RP_POS +: RP_W];
            end else if (rp_load_i) begin
                rp_ff <= rp_data_i;
            end
            if (wr_ptr && avs_byteenable_i[1]) begin
                dp_ff <= avs_writedata_i[CFB_DP_POS +: 3];
            end else if (dp_load_i) begin
                dp_ff <= dp_data_i;
            end
        end
    end

    // Last operation result
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            res_ff <= 8'h00;
        end else if (alu_go) begin
            res_ff <= alu_bus.res;
        end
    end

    cfb_addr_map #(
        .RP_W (RP_W)
    ) u_map (
        .dp_i (dp_ff),
        .dir_addr_i (dir_addr_i),
        .rp_i (rp_ff),
        .reg_num_i (reg_num_i),
        .dir_phys_o (map_dir),
        .gpr_phys_o (map_gpr)
    );

    // Registered physical addresses, one cycle after the request
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dir_phys_ff <= 11'h000;
            gpr_phys_ff <= '0;
        end else begin
            dir_phys_ff <= map_dir;
            gpr_phys_ff <= map_gpr;
        end
    end

    // Read data selection; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address_i)
            CFB_CCR_OFS: begin
                rd_mux[7:0] = ccr_o;
            end
            CFB_PTR_OFS: begin
                rd_mux[CFB_RP_POS +: RP_W] = rp_ff;
                rd_mux[CFB_DP_POS +: 3] = dp_ff;
            end
            CFB_STAT_OFS: begin
                rd_mux[CFB_RES_POS +: 8] = res_ff;
                rd_mux[CFB_TAKE_POS] = irq_take_o;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured each cycle the read is held
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= 32'h0000_0000;
        end else if (avs_read_i) begin
            rdata_ff <= rd_mux;
        end
    end

    // Condition code image
    always_comb begin
        ccr_o = 8'h00;
        ccr_o[CFB_H_POS] = h_ff;
        ccr_o[CFB_IE_POS] = ie_ff;
        ccr_o[CFB_IL_HI_POS:CFB_IL_LO_POS] = il_ff;
        ccr_o[CFB_N_POS] = n_ff;
        ccr_o[CFB_Z_POS] = z_ff;
        ccr_o[CFB_V_POS] = v_ff;
        ccr_o[CFB_C_POS] = c_ff;
    end

    assign avs_readdata_o = rdata_ff;
    assign alu_res_o = res_ff;
    assign dir_phys_o = dir_phys_ff;
    assign gpr_phys_o = gpr_phys_ff;

    // Checks on flag and pointer behaviour
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!resetn_i);

    half_carry_a: assert property (
        alu_go && !wr_ccr && !ccr_load_i && alu_bus.op == CFB_OP_ADD
        |=> h_ff == (({1'b0, $past(alu_bus.a[3:0])}
                      + {1'b0, $past(alu_bus.b[3:0])}) > 5'h0F))
        else $error("half carry wrong after add");

    irq_enable_a: assert property (
        !ie_ff |-> !irq_take_o)
        else $error("interrupt taken while disabled");

    irq_level_a: assert property (
        !wr_ccr && !ccr_load_i |=> il_ff == $past(il_ff))
        else $error("level field changed without a load");

    irq_priority_a: assert property (
        irq_take_o |-> irq_req_lvl_i < il_ff && il_ff != 2'h0)
        else $error("interrupt taken at too low a priority");

    neg_flag_a: assert property (
        alu_go && !wr_ccr && !ccr_load_i |=> n_ff == res_ff[7])
        else $error("negative flag differs from result");

    zero_flag_a: assert property (
        alu_go && !wr_ccr && !ccr_load_i |=> z_ff == (res_ff == 8'h00))
        else $error("zero flag differs from result");

    add_overflow_a: assert property (
        alu_go && !wr_ccr && !ccr_load_i && alu_bus.op == CFB_OP_ADD
        |=> v_ff == (($past(alu_bus.a[7]) == $past(alu_bus.b[7]))
                     && (res_ff[7] != $past(alu_bus.a[7]))))
        else $error("overflow flag wrong after add");

    add_carry_a: assert property (
        alu_go && !wr_ccr && !ccr_load_i && alu_bus.op == CFB_OP_ADD
        |=> c_ff == (({1'b0, $past(alu_bus.a)}
                      + {1'b0, $past(alu_bus.b)}) > 9'h0FF))
        else $error("carry flag wrong after add");

    shift_carry_a: assert property (
        alu_go && !wr_ccr && !ccr_load_i && alu_bus.op == CFB_OP_SHL
        |=> c_ff == $past(alu_bus.a[7]) && res_ff[0] == 1'b0)
        else $error("carry not loaded with shifted bit");

    dir_window_a: assert property (
        dir_addr_i[7]
        |=> dir_phys_o == ({1'b0, $past(dp_ff), 7'h00} + 11'h080
                           + {4'h0, $past(dir_addr_i[6:0])}))
        else $error("upper direct window mapped wrongly");

    dir_low_a: assert property (
        !dir_addr_i[7] |=> dir_phys_o == {3'h0, $past(dir_addr_i)})
        else $error("lower direct window was remapped");

    gpr_addr_a: assert property (
        rp_load_i && !wr_ptr |=> ##1 gpr_phys_o[RP_W+2:3] == $past(rp_data_i, 2))
        else $error("bank pointer not applied to register address");

    gpr_low_a: assert property (
        1'b1 |=> gpr_phys_o[2:0] == $past(reg_num_i))
        else $error("register number not in low address bits");
endmodule : cfb_core
`default_nettype wire

// ===== verilog/cfb_pkg.sv
// Constants and types shared by the flags and bank pointer block
package cfb_pkg;
    // Register byte offsets on the register bus
    localparam logic [4:0] CFB_CCR_OFS = 5'h00;
    localparam logic [4:0] CFB_PTR_OFS = 5'h04;
    localparam logic [4:0] CFB_ALU_OFS = 5'h08;
    localparam logic [4:0] CFB_STAT_OFS = 5'h0C;
    // Condition code bit positions
    localparam int CFB_C_POS = 0;
    localparam int CFB_V_POS = 1;
    localparam int CFB_Z_POS = 2;
    localparam int CFB_N_POS = 3;
    localparam int CFB_IL_LO_POS = 4;
    localparam int CFB_IL_HI_POS = 5;
    localparam int CFB_IE_POS = 6;
    localparam int CFB_H_POS = 7;
    // Condition code reset: interrupts off, level field 3 admits levels 0 to 2
    localparam logic [7:0] CFB_CCR_RST = 8'h30;
    // Pointer register fields
    localparam int CFB_RP_POS = 0;
    localparam int CFB_DP_POS = 8;
    localparam logic [2:0] CFB_DP_RST = 3'h0;
    // Software operation register fields
    localparam int CFB_OPA_POS = 0;
    localparam int CFB_OPB_POS = 8;
    localparam int CFB_OP_POS = 16;
    // Status register fields
    localparam int CFB_RES_POS = 0;
    localparam int CFB_TAKE_POS = 8;
    // Direct window remapping
    localparam logic [10:0] CFB_DIR_STEP = 11'h080;
    // Operations executed by the flag unit
    typedef enum logic [3:0] {
        CFB_OP_ADD,
        CFB_OP_ADDC,
        CFB_OP_SUB,
        CFB_OP_SUBC,
        CFB_OP_AND,
        CFB_OP_OR,
        CFB_OP_XOR,
        CFB_OP_SHL,
        CFB_OP_SHR
    } cfb_op_e;
endpackage : cfb_pkg

// ===== verilog/cfb_alu_if.sv
// Operand and flag bundle between the core and the flag unit
`timescale 1ns/1ps
`default_nettype none
interface cfb_alu_if;
    import cfb_pkg::*;
    cfb_op_e op;
    logic [7:0] a;
    logic [7:0] b;
    logic c_in;
    logic h_in;
    logic v_in;
    logic [7:0] res;
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
    modport core (output op, a, b, c_in, h_in, v_in,
                  input res, h, n, z, v, c);
    modport unit (input op, a, b, c_in, h_in, v_in,
                  output res, h, n, z, v, c);
endinterface : cfb_alu_if
`default_nettype wire

// ===== verilog/cfb_alu_unit.sv
// Combinational result and flag generation
`timescale 1ns/1ps
`default_nettype none
module cfb_alu_unit
    import cfb_pkg::*;
(
    cfb_alu_if.unit alu
);
    logic [8:0] wide;
    logic [4:0] nib;
    logic cin;

    // Result and flags per operation; unaffected flags pass through
    always_comb begin
        cin = 1'b0;
        wide = 9'h000;
        nib = 5'h00;
        alu.res = alu.a;
        alu.h = alu.h_in;
        alu.v = alu.v_in;
        alu.c = alu.c_in;
        case (alu.op)
            CFB_OP_ADD, CFB_OP_ADDC: begin
                cin = (alu.op == CFB_OP_ADDC) & alu.c_in;
                wide = {1'b0, alu.a} + {1'b0, alu.b} + {8'h00, cin};
                nib = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, cin};
                alu.res = wide[7:0];
                alu.h = nib[4];
                alu.c = wide[8];
                alu.v = (alu.a[7] == alu.b[7]) & (wide[7] != alu.a[7]);
            end
            CFB_OP_SUB, CFB_OP_SUBC: begin
                cin = (alu.op == CFB_OP_SUBC) & alu.c_in;
                wide = {1'b0, alu.a} - {1'b0, alu.b} - {8'h00, cin};
                nib = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]} - {4'h0, cin};
                alu.res = wide[7:0];
                alu.h = nib[4];
                alu.c = wide[8];
                alu.v = (alu.a[7] != alu.b[7]) & (wide[7] != alu.a[7]);
            end
            CFB_OP_AND: begin
                alu.res = alu.a & alu.b;
                alu.v = 1'b0;
            end
            CFB_OP_OR: begin
                alu.res = alu.a | alu.b;
                alu.v = 1'b0;
            end
            CFB_OP_XOR: begin
                alu.res = alu.a ^ alu.b;
                alu.v = 1'b0;
            end
            CFB_OP_SHL: begin
                alu.res = {alu.a[6:0], 1'b0};
                alu.c = alu.a[7];
                alu.v = 1'b0;
            end
            CFB_OP_SHR: begin
                alu.res = {1'b0, alu.a[7:1]};
                alu.c = alu.a[0];
                alu.v = 1'b0;
            end
            default: begin
                alu.res = alu.a;
            end
        endcase
        alu.n = alu.res[7];
        alu.z = (alu.res == 8'h00);
    end
endmodule : cfb_alu_unit
`default_nettype wire

// ===== verilog/cfb_addr_map.sv
// Physical address forming for direct and register operands
`timescale 1ns/1ps
`default_nettype none
module cfb_addr_map
    import cfb_pkg::*;
#(
    parameter int RP_W = 5
)
(
    input wire logic [2:0] dp_i,
    input wire logic [7:0] dir_addr_i,
    input wire logic [RP_W-1:0] rp_i,
    input wire logic [2:0] reg_num_i,
    output logic [10:0] dir_phys_o,
    output logic [RP_W+2:0] gpr_phys_o
);
    logic [10:0] bank_base;

    // Upper direct window moves by one step per pointer value
    always_comb begin
        bank_base = {1'b0, dp_i, 7'h00} + CFB_DIR_STEP;
        if (dir_addr_i[7]) begin
            dir_phys_o = bank_base | {4'h0, dir_addr_i[6:0]};
        end else begin
            dir_phys_o = {3'h0, dir_addr_i};
        end
    end

    // Bank pointer above, opcode register number below
    assign gpr_phys_o = {rp_i, reg_num_i};
endmodule : cfb_addr_map
`default_nettype wire

// ===== dv/cfb_core_tb_top.sv
// Self-checking bench for the flags and bank pointer core
`timescale 1ns/1ps
`default_nettype none
module cfb_core_tb_top
    import cfb_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdat;
    logic wait_o;
    logic alu_en = 1'b0;
    cfb_op_e op = CFB_OP_ADD;
    logic [7:0] a = 8'h00;
    logic [7:0] b = 8'h00;
    logic [7:0] res_o;
    logic ccr_ld = 1'b0;
    logic [7:0] ccr_d = 8'h00;
    logic [7:0] ccr_o;
    logic rp_ld = 1'b0;
    logic [4:0] rp_d = 5'h00;
    logic dp_ld = 1'b0;
    logic [2:0] dp_d = 3'h0;
    logic irq_req = 1'b0;
    logic [1:0] irq_lvl = 2'h0;
    logic take_o;
    logic [7:0] dir_a = 8'h00;
    logic [10:0] dir_o;
    logic [2:0] regn = 3'h0;
    logic [7:0] gpr_o;
    int miscompares = 0;
    int n_compared = 0;
    logic [15:0] lfsr_q = 16'h8D48;
    logic [7:0] exp_ccr = 8'h30;
    logic [15:0] exp_prev = 16'h0;
    logic [15:0] nxt = 16'h0;
    logic [31:0] got;
    logic [7:0] av;
    logic [7:0] bv;
    logic [7:0] da;
    int ex;
    int i;

    cfb_core #(.RP_W(5)) i_cfb_core (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
        .alu_en_i(alu_en), .alu_op_i(op), .alu_a_i(a), .alu_b_i(b),
        .alu_res_o(res_o), .ccr_load_i(ccr_ld), .ccr_data_i(ccr_d),
        .ccr_o(ccr_o), .rp_load_i(rp_ld), .rp_data_i(rp_d),
        .dp_load_i(dp_ld), .dp_data_i(dp_d), .irq_req_i(irq_req),
        .irq_req_lvl_i(irq_lvl), .irq_take_o(take_o),
        .dir_addr_i(dir_a), .dir_phys_o(dir_o), .reg_num_i(regn),
        .gpr_phys_o(gpr_o)
    );

    // Clock at 10 MHz
    always #50 sys_clk_i = ~sys_clk_i;

    // Pseudo-random source
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // Reference result and condition code; IE and level kept
    function automatic logic [15:0] alu_model(input int o,
            input logic [7:0] x, input logic [7:0] y, input logic [7:0] cc);
        int r;
        int ci;
        logic [7:0] f;
        f = cc;
        ci = (o == 1 || o == 3) ? int'(cc[0]) : 0;
        r = x;
        case (o)
            0, 1: begin
                r = x + y + ci;
                f[7] = ((x & 15) + (y & 15) + ci) > 15;
                f[0] = r > 255;
                f[1] = (x[7] == y[7]) && (r[7] != x[7]);
            end
            2, 3: begin
                r = x - y - ci;
                f[7] = (x & 15) < ((y & 15) + ci);
                f[0] = x < (y + ci);
                f[1] = (x[7] != y[7]) && (r[7] != x[7]);
            end
            4: r = x & y;
            5: r = x | y;
            6: r = x ^ y;
            7: begin
                r = x << 1;
                f[0] = x[7];
            end
            default: begin
                r = x >> 1;
                f[0] = x[0];
            end
        endcase
        if (o >= 4) begin
            f[1] = 1'b0;
        end
        f[3] = r[7];
        f[2] = (r & 255) == 0;
        return {r[7:0], f};
    endfunction : alu_model

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask : check

    // One Avalon-MM transfer, held until waitrequest is low
    task automatic bus(input logic w, input logic [4:0] ad,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge sys_clk_i);
        rd <= !w;
        wr <= w;
        adr <= ad;
        wdat <= d;
        n = 0;
        // Sample waitrequest and read data at the rising edge only
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (wait_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    // Verdict and end of run
    task automatic conclude();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Hang guard
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        miscompares++;
        conclude();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(negedge sys_clk_i);
        check(ccr_o, 32'h30);
        bus(1'b0, CFB_CCR_OFS, 32'h0, got);
        check(got, 32'h30);
        bus(1'b0, 5'h10, 32'h0, got);
        check(got, 32'h0);
        $display("test reset done");
        // Back-to-back operations, every code
        for (i = 0; i <= 36; i++) begin
            @(posedge sys_clk_i);
            if (i < 36) begin
                lfsr_q = lfsr_next(lfsr_q);
                av = (i < 9) ? 8'hFF : lfsr_q[7:0];
                bv = (i < 9) ? 8'h01 : lfsr_q[15:8];
                alu_en <= 1'b1;
                op <= cfb_op_e'(i % 9);
                a <= av;
                b <= bv;
                nxt = alu_model(i % 9, av, bv, exp_ccr);
            end else begin
                alu_en <= 1'b0;
            end
            @(negedge sys_clk_i);
            if (i > 0) begin
                check(res_o, exp_prev[15:8]);
                check(ccr_o, exp_prev[7:0]);
            end
            exp_prev = nxt;
            exp_ccr = nxt[7:0];
        end
        $display("test alu done");
        // Register access over the bus
        bus(1'b1, CFB_CCR_OFS, 32'hC5, got);
        exp_ccr = 8'hC5;
        bus(1'b0, CFB_CCR_OFS, 32'h0, got);
        check(got, 32'hC5);
        bus(1'b1, CFB_ALU_OFS, 32'h0000_017F, got);
        nxt = alu_model(0, 8'h7F, 8'h01, exp_ccr);
        bus(1'b0, CFB_STAT_OFS, 32'h0, got);
        check(got[8:0], {1'b0, nxt[15:8]});
        check(ccr_o, nxt[7:0]);
        exp_ccr = nxt[7:0];
        be <= 4'h8;
        bus(1'b1, CFB_ALU_OFS, 32'h0002_0101, got);
        be <= 4'hF;
        bus(1'b0, CFB_ALU_OFS, 32'h0, got);
        check(got, 32'h0);
        check(res_o, nxt[15:8]);
        bus(1'b1, 5'h14, 32'hFF, got);
        bus(1'b0, CFB_CCR_OFS, 32'h0, got);
        check(got, {24'h0, exp_ccr});
        bus(1'b1, CFB_PTR_OFS, 32'h0000_0513, got);
        bus(1'b0, CFB_PTR_OFS, 32'h0, got);
        check(got, 32'h0000_0513);
        $display("test bus done");
        // Interrupt gate over every enable, level and request
        for (i = 0; i < 64; i++) begin
            @(posedge sys_clk_i);
            ccr_ld <= 1'b1;
            ccr_d <= {1'b0, i[4], i[3:2], 4'h0};
            irq_req <= i[5];
            irq_lvl <= i[1:0];
            @(posedge sys_clk_i);
            ccr_ld <= 1'b0;
            @(negedge sys_clk_i);
            check(take_o, i[5] && i[4] && (i[1:0] < i[3:2]));
        end
        $display("test irq done");
        // Direct window and register bank addressing
        for (i = 0; i < 64; i++) begin
            @(posedge sys_clk_i);
            lfsr_q = lfsr_next(lfsr_q);
            case (i / 8)
                0: da = 8'h00;
                1: da = 8'h7F;
                2: da = 8'h80;
                3: da = 8'hFF;
                default: da = lfsr_q[15:8];
            endcase
            dp_ld <= 1'b1;
            dp_d <= i[2:0];
            rp_ld <= 1'b1;
            rp_d <= lfsr_q[4:0];
            regn <= lfsr_q[7:5];
            dir_a <= da;
            @(posedge sys_clk_i);
            dp_ld <= 1'b0;
            rp_ld <= 1'b0;
            repeat (2) @(posedge sys_clk_i);
            @(negedge sys_clk_i);
            ex = (da < 128) ? da : (i % 8) * 128 + da;
            check(dir_o, ex);
            check(gpr_o, {lfsr_q[4:0], lfsr_q[7:5]});
        end
        $display("test map done");
        conclude();
    end
endmodule : cfb_core_tb_top
`default_nettype wire
